/* File: hw/mac_flow_control.sv */
// flow-control block of the mac: config register, pause send and obey,
// half-duplex back pressure and receive status for control frames
// assumes an ahb-lite single-slave bus and mac signals on the same clock
//
// How it works
// - pause time field goes into sent frame
// - sent frame follows standard control layout
// - busy held from pause start until sent
// - busy held while back pressure applied
// - no new pause send, no back pressure, transmitter off
// - enabled: valid pause holds transmitter time*slot
// - disabled: no control decode, pause not obeyed
// - pause only full duplex; half: backpressure
// - pass bit forwards pause, still obeys it
// - pass bit clear clears filter status
// - every received frame handed on always
// - promiscuous mode overrides pass bit
// - software flow started via request register
// - register resets zero, bits 15:3 reserved
`timescale 1ns/1ps
`include "mac_flow_regs.svh"

module mac_flow_control
  import mac_flow_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // mac configuration
  input  wire logic        full_duplex,
  input  wire logic        tx_enable,
  input  wire logic        speed_100,
  input  wire logic        promiscuous,
  input  wire logic [47:0] mac_addr,
  // pause frame, hold-off and back pressure towards transmitter
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output tx_byte_t         tx_out,
  output logic             tx_hold_off,
  output logic             backpressure,
  // receive side
  input  rx_hdr_t          rx_hdr,
  output logic             rx_status_valid,
  output rx_stat_t         rx_status
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic [15:0] pause_time_value;
  logic        pass_control_frames;
  logic        flow_control_enable;
  logic        flow_control_busy;
  logic        send_req_q;
  logic        bp_req_q;
  logic        send_start;
  logic        send_done;
  fc_state_t   state_q;

  // register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [31:0] a);
    return a[9:2];
  endfunction

  logic addr_ok;
  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1; // zero wait states, every access completes
  assign hresp     = 1'b0;

  // capture write address phase, apply in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q  <= reg_idx(haddr);
    end
  end

  // read data registered in the address phase, valid in data phase
  always_ff @(posedge clk) begin
    if (rst) hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite) begin
      case (reg_idx(haddr))
        `FLOW_CFG_IDX: hrdata <= {pause_time_value, 13'h0000,
                                  pass_control_frames, flow_control_enable,
                                  flow_control_busy};
        `FLOW_REQ_IDX: hrdata <= {30'h0000_0000, bp_req_q, send_req_q};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration register

  // busy is status only; the write value of bit 0 is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      pause_time_value    <= 16'(`FLOW_CFG_RST >> `PT_LSB);
      pass_control_frames <= 1'b0;
      flow_control_enable <= 1'b0;
    end else if (wr_pend_q && wr_idx_q == `FLOW_CFG_IDX) begin
      pause_time_value    <= hwdata[`PT_MSB:`PT_LSB];
      pass_control_frames <= hwdata[`PASS_BIT];
      flow_control_enable <= hwdata[`FLOW_CONTROL_ENABLE_BIT];
    end
  end

  // software request: send is a request flag, set wins over the clear at send start
  always_ff @(posedge clk) begin
    if (rst) begin
      send_req_q <= 1'b0;
      bp_req_q   <= 1'b0;
    end else begin
      if (wr_pend_q && wr_idx_q == `FLOW_REQ_IDX) begin
        bp_req_q <= hwdata[`REQ_BP_BIT];
      end
      if (wr_pend_q && wr_idx_q == `FLOW_REQ_IDX && hwdata[`REQ_SEND_BIT]) begin
        send_req_q <= 1'b1;
      end else if (send_start) begin
        send_req_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit side: pause send or back pressure

  logic fd_tx_ok;
  logic hd_bp_ok;
  assign fd_tx_ok   = full_duplex && tx_enable;
  assign hd_bp_ok   = !full_duplex && tx_enable && flow_control_enable && bp_req_q;
  assign send_start = state_q == FC_IDLE && send_req_q && fd_tx_ok;

  // a send in progress always completes so no truncated frame leaves
  always_ff @(posedge clk) begin
    if (rst) state_q <= FC_IDLE;
    else begin
      case (state_q)
        FC_IDLE: begin
          if (send_start) state_q <= FC_SEND;
          else if (hd_bp_ok) state_q <= FC_BACKP;
        end
        FC_SEND: if (send_done) state_q <= FC_IDLE;
        FC_BACKP: if (!hd_bp_ok) state_q <= FC_IDLE;
        default: state_q <= FC_IDLE;
      endcase
    end
  end

  assign flow_control_busy = state_q != FC_IDLE;

  // back pressure output registered to keep it glitch-free
  always_ff @(posedge clk) begin
    if (rst) backpressure <= 1'b0;
    else backpressure <= state_q == FC_IDLE ? hd_bp_ok :
                         state_q == FC_BACKP && hd_bp_ok;
  end

  pause_frame_gen u_gen (
    .clk        (clk),
    .rst        (rst),
    .start      (send_start),
    .src_addr   (mac_addr),
    .pause_time (pause_time_value),
    .tx_ready   (tx_ready),
    .tx_valid   (tx_valid),
    .tx_out     (tx_out),
    .done       (send_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive side: control frame decode and pause timer

  // control frame test, used for both the pause action and status
  function automatic logic is_ctrl(input rx_hdr_t h);
    return h.len_type == `CTRL_TYPE;
  endfunction

  logic pause_hit;
  assign pause_hit = rx_hdr.valid && flow_control_enable && full_duplex &&
                     is_ctrl(rx_hdr) && rx_hdr.crc_ok && rx_hdr.dest == `PAUSE_DA &&
                     rx_hdr.opcode == `PAUSE_OPC;

  // slot tick divider; a pause restarts the slot, a speed change does not
  logic [11:0] slot_cnt_q;
  logic        slot_tick;
  logic [11:0] slot_len;
  assign slot_len  = speed_100 ? 12'(`SLOT_CYC_100 - 1) : 12'(`SLOT_CYC_10 - 1);
  assign slot_tick = slot_cnt_q == slot_len;

  always_ff @(posedge clk) begin
    if (rst || pause_hit || slot_tick) slot_cnt_q <= 12'h000;
    else slot_cnt_q <= slot_cnt_q + 12'h001;
  end

  // quanta left; a new pause replaces the old time, zero releases at once
  logic [15:0] quanta_q;
  always_ff @(posedge clk) begin
    if (rst) quanta_q <= 16'h0000;
    else if (pause_hit) quanta_q <= rx_hdr.pause_time;
    else if (!flow_control_enable || !full_duplex) quanta_q <= 16'h0000;
    else if (slot_tick && quanta_q != 16'h0000) quanta_q <= quanta_q - 16'h0001;
  end

  assign tx_hold_off = quanta_q != 16'h0000;

  // status per frame; frame data itself never blocked here
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_status_valid <= 1'b0;
      rx_status       <= '0;
    end else begin
      rx_status_valid   <= rx_hdr.valid;
      rx_status.is_ctrl <= flow_control_enable && is_ctrl(rx_hdr);
      if (promiscuous) rx_status.filter_ok <= 1'b1;
      else if (flow_control_enable && is_ctrl(rx_hdr))
        rx_status.filter_ok <= pass_control_frames && rx_hdr.addr_match;
      else rx_status.filter_ok <= rx_hdr.addr_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // a pause send has two steps: request taken, then the frame on offer
  sequence s_send_go;
    send_start;
  endsequence

  sequence s_send_on;
    flow_control_busy && tx_valid;
  endsequence

  chk_busy_send: assert property (@(posedge clk) disable iff (rst)
    s_send_go |=> s_send_on)
    else $error("busy dropped during pause send");
  chk_busy_frame: assert property (@(posedge clk) disable iff (rst)
    tx_valid |-> flow_control_busy)
    else $error("frame byte offered while not busy");
  chk_busy_clears: assert property (@(posedge clk) disable iff (rst)
    send_done |=> !flow_control_busy)
    else $error("busy held after pause sent");
  chk_busy_backp: assert property (@(posedge clk) disable iff (rst)
    backpressure |-> flow_control_busy)
    else $error("back pressure without busy");
  chk_tx_off: assert property (@(posedge clk) disable iff (rst)
    !tx_enable |=> !backpressure && !$rose(state_q == FC_SEND))
    else $error("flow action with transmitter off");
  chk_pause_hold: assert property (@(posedge clk) disable iff (rst)
    pause_hit && rx_hdr.pause_time != 16'h0000 |=> tx_hold_off[*2])
    else $error("pause not obeyed");
  chk_no_decode: assert property (@(posedge clk) disable iff (rst)
    !flow_control_enable |=> !tx_hold_off)
    else $error("pause acted while disabled");
  chk_hd_no_pause: assert property (@(posedge clk) disable iff (rst)
    !full_duplex |=> !tx_hold_off)
    else $error("pause held in half duplex");
  chk_filter_clear: assert property (@(posedge clk) disable iff (rst)
    rx_hdr.valid && flow_control_enable && is_ctrl(rx_hdr) && !pass_control_frames
    && !promiscuous |=> !rx_status.filter_ok)
    else $error("filter bit set for control frame");
  chk_fwd_all: assert property (@(posedge clk) disable iff (rst)
    rx_hdr.valid |=> rx_status_valid)
    else $error("frame status missing");
  chk_promisc_wins: assert property (@(posedge clk) disable iff (rst)
    rx_hdr.valid && promiscuous |=> rx_status.filter_ok)
    else $error("promiscuous did not override");
  chk_reset_val: assert property (@(posedge clk)
    rst |=> pause_time_value == 16'h0000 && !flow_control_enable && !pass_control_frames)
    else $error("config not zero after reset");

endmodule

/* File: inc/mac_flow_regs.svh */
// register map, field positions and timing counts for the flow-control block
// assumes word-indexed registers: byte address is four times the index
`ifndef MAC_FLOW_REGS_SVH
`define MAC_FLOW_REGS_SVH

// register indices (byte address = index * 4)
`define FLOW_CFG_IDX   8'h08
`define FLOW_REQ_IDX   8'h10

// flow_control_config fields
`define PT_MSB         31
`define PT_LSB         16
`define PASS_BIT       2
`define FLOW_CONTROL_ENABLE_BIT       1
`define BUSY_BIT       0
`define FLOW_CFG_RST   32'h0000_0000

// auto_flow_config request fields
`define REQ_SEND_BIT   0
`define REQ_BP_BIT     1

// slot time: 512 bit times, counted in 50 MHz clocks
`define CLK_NS         20
`define BIT_NS_100     10
`define BIT_NS_10      100
`define SLOT_BITS      512
`define SLOT_CYC_100   ((`SLOT_BITS * `BIT_NS_100) / `CLK_NS)
`define SLOT_CYC_10    ((`SLOT_BITS * `BIT_NS_10) / `CLK_NS)

// pause control frame constants
`define PAUSE_DA       48'h0180_C200_0001
`define CTRL_TYPE      16'h8808
`define PAUSE_OPC      16'h0001
`define PAUSE_LEN      6'h3C

`endif

/* File: inc/mac_flow_pkg.sv */
// types shared by the flow-control block and its frame generator
// assumes nothing beyond a SystemVerilog compiler
package mac_flow_pkg;

  // header fields of a received frame, one-cycle valid at frame end
  typedef struct packed {
    logic        valid;
    logic        crc_ok;
    logic        addr_match;
    logic [47:0] dest;
    logic [15:0] len_type;
    logic [15:0] opcode;
    logic [15:0] pause_time;
  } rx_hdr_t;

  // one byte of an outgoing control frame
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tx_byte_t;

  // per-frame receive status
  typedef struct packed {
    logic is_ctrl;
    logic filter_ok;
  } rx_stat_t;

  typedef enum logic [1:0] {FC_IDLE, FC_SEND, FC_BACKP} fc_state_t;

endpackage

/* File: hw/pause_frame_gen.sv */
// serialiser for one pause control frame, 60 bytes before the crc
// assumes the mac transmitter appends crc and takes a byte on valid && ready
`timescale 1ns/1ps
`include "mac_flow_regs.svh"

module pause_frame_gen
  import mac_flow_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [47:0] src_addr,
  input  wire logic [15:0] pause_time,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output tx_byte_t         tx_out,
  output logic             done
);

  logic        active_q;
  logic [5:0]  idx_q;
  logic [15:0] pt_q;
  logic [47:0] sa_q;
  logic        take;

  // field layout: da, sa, type, opcode, pause time, zero pad
  function automatic logic [7:0] frame_byte(input logic [5:0] i,
                                            input logic [47:0] sa,
                                            input logic [15:0] pt);
    logic [7:0] b;
    b = 8'h00;
    if (i < 6'h06) b = 8'(`PAUSE_DA >> (8 * (5 - i)));
    else if (i < 6'h0C) b = 8'(sa >> (8 * (11 - i)));
    else if (i == 6'h0C) b = 8'(`CTRL_TYPE >> 8);
    else if (i == 6'h0D) b = 8'(`CTRL_TYPE);
    else if (i == 6'h0E) b = 8'(`PAUSE_OPC >> 8);
    else if (i == 6'h0F) b = 8'(`PAUSE_OPC);
    else if (i == 6'h10) b = pt[15:8];
    else if (i == 6'h11) b = pt[7:0];
    return b;
  endfunction

  assign take     = active_q && tx_ready;
  assign tx_valid = active_q;
  assign done     = take && (idx_q == `PAUSE_LEN - 6'h01);

  // frame progress; values latched at start so a later write cannot tear it
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      idx_q    <= 6'h00;
      pt_q     <= 16'h0000;
      sa_q     <= 48'h0000_0000_0000;
    end else if (start && !active_q) begin
      active_q <= 1'b1;
      idx_q    <= 6'h00;
      pt_q     <= pause_time;
      sa_q     <= src_addr;
    end else if (take) begin
      idx_q    <= idx_q + 6'h01;
      if (done) active_q <= 1'b0;
    end
  end

  // data from flip-flops: the byte is rebuilt from latched fields
  always_ff @(posedge clk) begin
    if (rst) tx_out <= '0;
    else begin
      tx_out.data <= frame_byte(take ? idx_q + 6'h01 : idx_q, sa_q, pt_q);
      tx_out.last <= (take ? idx_q + 6'h01 : idx_q) == `PAUSE_LEN - 6'h01;
      if (start && !active_q) begin
        tx_out.data <= 8'h01;
        tx_out.last <= 1'b0;
      end
    end
  end

  chk_pause_time_byte: assert property (@(posedge clk) disable iff (rst)
    tx_valid && idx_q == 6'h10 |-> tx_out.data == pt_q[15:8])
    else $error("pause time high byte wrong");
  chk_frame_type: assert property (@(posedge clk) disable iff (rst)
    tx_valid && idx_q == 6'h0C |-> tx_out.data == 8'h88)
    else $error("control type byte wrong");

endmodule

/* File: testbench/link_partner.sv */
// link partner model: takes pause frame bytes, sends received-frame headers
// assumes one 50 MHz clock shared with the flow-control block
`timescale 1ns/1ps

module link_partner
  import mac_flow_pkg::*;
(
  input  wire logic clk,
  input  wire logic tx_valid,
  input  tx_byte_t  tx_out,
  output logic      tx_ready,
  output rx_hdr_t   rx_hdr
);
  logic [7:0] cap[$];
  int         n_last;
  logic [1:0] ph;

  initial begin
    tx_ready = 1'b0;
    rx_hdr   = '0;
    ph       = 2'h0;
    n_last   = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stall one cycle in four so both prompt and slow takes occur
  always @(posedge clk) begin
    ph       <= ph + 2'h1;
    tx_ready <= (ph != 2'h2);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      cap.push_back(tx_out.data);
      if (tx_out.last === 1'b1) n_last <= n_last + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one header pulse; afterwards fields are inverted so stale data never matches
  task automatic send(input logic [15:0] t, input logic [15:0] op, input logic m);
    rx_hdr_t r;
    @(posedge clk);
    rx_hdr <= '{1'b1, 1'b1, m, 48'h0180_C200_0001, 16'h8808, op, t};
    @(posedge clk);
    r       = ~rx_hdr;
    r.valid = 1'b0;
    rx_hdr <= r;
  endtask
endmodule

/* File: testbench/test_mac_flow_control.sv */
// self-checking bench for the flow-control block
// assumes an ahb-lite master model here and the link partner model beside it
`timescale 1ns/1ps

module test_mac_flow_control import mac_flow_pkg::*;;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, full_duplex, tx_enable;
  logic        speed_100, promiscuous, tx_ready, tx_valid, tx_hold_off, backpressure;
  logic        rx_status_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [47:0] mac_addr;
  tx_byte_t    tx_out;
  rx_hdr_t     rx_hdr;
  rx_stat_t    rx_status;
  int          n_mismatch, total_checks;
  // byte addresses: register index times four
  localparam logic [31:0] CFG_A = 32'h0000_0020;
  localparam logic [31:0] REQ_A = 32'h0000_0040;

  mac_flow_control i_mac_flow_control (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .full_duplex(full_duplex),
    .tx_enable(tx_enable), .speed_100(speed_100), .promiscuous(promiscuous),
    .mac_addr(mac_addr), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_out(tx_out),
    .tx_hold_off(tx_hold_off), .backpressure(backpressure),
    .rx_hdr(rx_hdr), .rx_status_valid(rx_status_valid), .rx_status(rx_status));
  link_partner i_link_partner (.clk(clk), .tx_valid(tx_valid), .tx_out(tx_out),
    .tx_ready(tx_ready), .rx_hdr(rx_hdr));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a spent bound is a hang: count it and stop
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(0, CFG_A, 0);
    chk(rd, 32'h0000_0000);
    bus(1, CFG_A, 32'hFFFF_FFFE);
    bus(0, CFG_A, 0);
    chk(rd, 32'hFFFF_0006);
    bus(0, 32'h0000_00C0, 0);
    chk(rd, 32'h0000_0000);
    bus(1, CFG_A, 32'h0000_0000);
  endtask

  // request held off by a disabled transmitter, then sent whole
  task automatic t_send();
    logic [143:0] hdr;
    int           i;
    full_duplex <= 1'b1;
    bus(1, CFG_A, 32'h1234_0002);
    bus(1, REQ_A, 32'h0000_0001);
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      chk(tx_valid, 1'b0);
    end
    tx_enable <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, CFG_A, 0);
    chk(rd[0], 1'b1);
    i = 0;
    while (i_link_partner.n_last != 1 && i < 400) begin
      @(posedge clk);
      i++;
    end
    if (i >= 400) begin
      n_mismatch++;
      final_report();
    end
    chk(i_link_partner.cap.size(), 60);
    hdr = {48'h0180_C200_0001, mac_addr, 16'h8808, 16'h0001, 16'h1234};
    for (i = 0; i < 60 && i < i_link_partner.cap.size(); i++)
      chk(i_link_partner.cap[i], (i < 18) ? hdr[8*(17-i)+:8] : 8'h00);
    repeat (2) @(posedge clk);
    bus(0, CFG_A, 0);
    chk(rd[0], 1'b0);
  endtask

  // receive one header and judge status and the hold-off length
  task automatic rx_chk(input logic [15:0] t, input logic ctl, input logic flt, input int hold);
    int n;
    i_link_partner.send(t, 16'h0001, 1'b1);
    @(posedge clk);
    chk(rx_status_valid, 1'b1);
    chk({rx_status.is_ctrl, rx_status.filter_ok}, {ctl, flt});
    n = 0;
    while (tx_hold_off === 1'b1 && n < 6000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 6000) begin
      n_mismatch++;
      final_report();
    end
    chk(n, hold);
  endtask

  task automatic t_bp();
    full_duplex <= 1'b0;
    tx_enable   <= 1'b0;
    bus(1, REQ_A, 32'h0000_0002);
    repeat (5) @(posedge clk);
    chk(backpressure, 1'b0);
    tx_enable <= 1'b1;
    repeat (3) @(posedge clk);
    chk(backpressure, 1'b1);
    bus(0, CFG_A, 0);
    chk(rd[0], 1'b1);
    rx_chk(16'h0002, 1'b1, 1'b0, 0);
    bus(1, REQ_A, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(backpressure, 1'b0);
  endtask

  task automatic t_rx();
    full_duplex <= 1'b1;
    bus(0, CFG_A, 0);
    chk(rd[0], 1'b0);
    bus(1, CFG_A, 32'h0002_0006);
    rx_chk(16'h0002, 1'b1, 1'b1, 2 * 256);
    speed_100 <= 1'b0;
    rx_chk(16'h0001, 1'b1, 1'b1, 2560);
    bus(1, CFG_A, 32'h0002_0002);
    rx_chk(16'h0000, 1'b1, 1'b0, 0);
    // control frame with a foreign opcode must not hold the transmitter
    i_link_partner.send(16'h0002, 16'h0002, 1'b1);
    repeat (2) @(posedge clk);
    chk(tx_hold_off, 1'b0);
    promiscuous <= 1'b1;
    rx_chk(16'h0000, 1'b1, 1'b1, 0);
    promiscuous <= 1'b0;
    bus(1, CFG_A, 32'h0002_0004);
    rx_chk(16'h0002, 1'b0, 1'b1, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, hsel, hwrite, full_duplex, tx_enable, promiscuous} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    rst = 1'b1;
    speed_100 = 1'b1;
    mac_addr = 48'h0A1B_2C3D_4E5F;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({tx_valid, tx_hold_off, backpressure, rx_status_valid}, 4'h0);
    t_regs();
    t_send();
    t_bp();
    t_rx();
    final_report();
  end

  // watchdog against a hang outside the bounded loops
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end
endmodule
